// ### core/lnmc_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "lnmc_defs.svh"

module lnmc_fifo #(
   parameter int WIDTH = `LNMC_EVT_W,
   parameter int DEPTH = `LNMC_FIFO_DEPTH
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             out_valid,
   input  wire logic             out_ready,
   output var  logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;
   logic [AW-1:0]    next_rd_ptr;

   assign push = in_valid && in_ready;
   assign pop  = out_valid && out_ready;
   assign next_rd_ptr = !pop ? rd_ptr : (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

   // head word registered; a push into an emptying queue bypasses storage
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
      if (push && wr_ptr == next_rd_ptr) begin
         out_data <= in_data;
      end else begin
         out_data <= mem[next_rd_ptr];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count     <= count + 1'b1;
            in_ready  <= (count != (AW + 1)'(DEPTH - 1));
            out_valid <= 1'b1;
         end else if (pop && !push) begin
            count     <= count - 1'b1;
            in_ready  <= 1'b1;
            out_valid <= (count != (AW + 1)'(1));
         end
      end
   end
endmodule

module lnmc_core import lnmc_pkg::*; #(
   parameter int TX_TO_CYC  = `LNMC_TX_TO_US * `LNMC_CLK_MHZ,
   parameter int BUS_TO_CYC = `LNMC_BUS_TO_US * `LNMC_CLK_MHZ
) (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       lin_tx_input,
   input  wire logic       lin_bus_in,
   output var  logic       lin_bus_drive,
   output var  logic       lin_rx_output,
   output var  logic       interrupt_out_n,
   input  wire logic [2:0] dev_mode,
   input  wire logic [1:0] trx_mode_req,
   input  wire logic       trx_mode_wr,
   output var  logic [1:0] trx_mode_rd,
   input  wire logic       battery_side_supply_uv,
   input  wire logic       serial_select_n,
   input  wire logic       low_slope_select,
   input  wire logic       flash_select,
   output var  logic       slope_low,
   output var  logic       slope_off,
   input  wire logic       wake_enables_watchdog,
   input  wire logic       watchdog_active,
   output var  logic       watchdog_enable_set,
   output var  logic       restart_req,
   output var  logic       wake_status_reg,
   input  wire logic       wake_status_clr,
   output var  logic       lin_fail,
   input  wire logic       lin_fail_clr,
   output var  logic       wake_evt_valid,
   output var  logic [2:0] wake_evt_mode,
   input  wire logic       wake_evt_ready
);
   localparam lnmc_cnt_t EN_LIM   = lnmc_cnt_t'(`LNMC_EN_CYC);
   localparam lnmc_cnt_t WAKE_LIM = lnmc_cnt_t'(`LNMC_WAKE_FILT_CYC);
   localparam lnmc_cnt_t TX_LIM   = lnmc_cnt_t'(TX_TO_CYC);
   localparam lnmc_cnt_t BUS_LIM  = lnmc_cnt_t'(BUS_TO_CYC);
   localparam lnmc_cnt_t INT_LIM  = lnmc_cnt_t'(`LNMC_INT_PULSE_CYC);
   localparam logic [3:0] SYNC_RST = `LNMC_SYNC_RST;

   wire logic  [3:0] sync_b;
   logic       tx_s, bus_s, uv_s, csn_s;
   logic       bus_prev, csn_prev;
   lnmc_dev_t  dev, dev_prev;
   lnmc_trx_t  trx, next_trx;
   logic       wake_armed, rx_hold, wake_det, wake_pend, wk_active;
   logic       tx_armed, en_done, tx_to, tx_to_evt, clamp_evt, fifo_ready;
   lnmc_cnt_t  en_cnt, wk_cnt, tx_cnt, bus_cnt, int_cnt;
   logic       dev_norm, dev_stop, dev_sleep, dev_fs, fs_entry, rearm_entry;

   // two-stage synchronisers for pin inputs
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         logic a, b;
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               a <= SYNC_RST[gi];
               b <= SYNC_RST[gi];
            end else begin
               a <= (gi == 0) ? lin_tx_input : (gi == 1) ? lin_bus_in :
                    (gi == 2) ? battery_side_supply_uv : serial_select_n;
               b <= a;
            end
         end
         assign sync_b[gi] = b;
      end
   endgenerate
   assign tx_s  = sync_b[0];
   assign bus_s = sync_b[1];
   assign uv_s  = sync_b[2];
   assign csn_s = sync_b[3];

   assign dev         = lnmc_dev_t'(dev_mode);
   assign dev_norm    = (dev == DEV_NORMAL);
   assign dev_stop    = (dev == DEV_STOP);
   assign dev_sleep   = (dev == DEV_SLEEP);
   assign dev_fs      = (dev == DEV_FAILSAFE);
   assign fs_entry    = dev_fs && (dev_prev != DEV_FAILSAFE);
   assign rearm_entry = (dev != dev_prev) && (dev_stop || dev_sleep || dev_fs);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_prev <= 1'b1;
         csn_prev <= 1'b1;
         dev_prev <= DEV_NORMAL;
      end else begin
         bus_prev <= bus_s;
         csn_prev <= csn_s;
         dev_prev <= dev;
      end
   end

   // transceiver mode selection
   always_comb begin
      next_trx = trx;
      if (fs_entry) begin
         next_trx = TRX_WAKE;
      end else if (trx_mode_wr) begin
         unique case (trx_mode_req)
            `LNMC_MODE_OFF: next_trx = TRX_OFF;
            `LNMC_MODE_WAKE: begin
               if (!dev_fs) begin
                  next_trx = TRX_WAKE;
               end
            end
            `LNMC_MODE_RXO: begin
               if (dev_norm || dev_stop) begin
                  next_trx = TRX_RXO;
               end
            end
            `LNMC_MODE_NORM: begin
               if (dev_norm || dev_stop) begin
                  next_trx = TRX_NORM;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         trx         <= TRX_OFF;
         trx_mode_rd <= `LNMC_MODE_OFF;
      end else begin
         trx <= next_trx;
         unique case (next_trx)
            TRX_OFF:  trx_mode_rd <= `LNMC_MODE_OFF;
            TRX_WAKE: trx_mode_rd <= `LNMC_MODE_WAKE;
            TRX_RXO:  trx_mode_rd <= `LNMC_MODE_RXO;
            TRX_NORM: trx_mode_rd <= `LNMC_MODE_NORM;
         endcase
      end
   end

   // enabling time and fresh-dominant arming
   assign en_done = (en_cnt >= EN_LIM);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_cnt   <= '0;
         tx_armed <= 1'b0;
      end else begin
         if (trx != TRX_NORM) begin
            en_cnt <= '0;
         end else if (!en_done) begin
            en_cnt <= en_cnt + 1'b1;
         end
         if (trx != TRX_NORM || !en_done) begin
            tx_armed <= 1'b0;
         end else if (tx_s) begin
            tx_armed <= 1'b1;
         end
      end
   end

   // transmit dominant time-out and bus clamping
   assign tx_to_evt = (trx == TRX_NORM) && !tx_s && (tx_cnt == TX_LIM - 1'b1);
   assign clamp_evt = (trx == TRX_NORM || trx == TRX_RXO) && !bus_s
                      && (bus_cnt == BUS_LIM - 1'b1);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_cnt  <= '0;
         bus_cnt <= '0;
         tx_to   <= 1'b0;
      end else begin
         if (tx_s || trx != TRX_NORM) begin
            tx_cnt <= '0;
         end else if (tx_cnt != TX_LIM) begin
            tx_cnt <= tx_cnt + 1'b1;
         end
         if (bus_s || !(trx == TRX_NORM || trx == TRX_RXO)) begin
            bus_cnt <= '0;
         end else if (bus_cnt != BUS_LIM) begin
            bus_cnt <= bus_cnt + 1'b1;
         end
         if (tx_s) begin
            tx_to <= 1'b0;
         end else if (tx_to_evt) begin
            tx_to <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lin_fail <= 1'b0;
      end else if (tx_to_evt || clamp_evt) begin
         lin_fail <= 1'b1;
      end else if (lin_fail_clr) begin
         lin_fail <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lin_bus_drive <= 1'b0;
      end else begin
         lin_bus_drive <= (trx == TRX_NORM) && tx_armed && !tx_s && !tx_to
                          && !uv_s;
      end
   end

   // bus wake detection
   assign wake_det = wk_active && (trx == TRX_WAKE) && !uv_s && !bus_prev && bus_s
                     && (wk_cnt >= WAKE_LIM);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wk_active <= 1'b0;
         wk_cnt    <= '0;
      end else begin
         if (trx != TRX_WAKE || !wake_armed || wake_pend || uv_s || bus_s) begin
            wk_active <= 1'b0;
            wk_cnt    <= '0;
         end else if (bus_prev) begin
            wk_active <= 1'b1;
            wk_cnt    <= '0;
         end else if (wk_cnt != WAKE_LIM) begin
            wk_cnt <= wk_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_armed <= 1'b0;
      end else if (wake_det) begin
         wake_armed <= 1'b0;
      end else if (rearm_entry || (next_trx == TRX_WAKE && trx != TRX_WAKE)) begin
         wake_armed <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_hold <= 1'b0;
      end else if (wake_det) begin
         rx_hold <= 1'b1;
      end else if (next_trx != TRX_WAKE) begin
         rx_hold <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lin_rx_output <= 1'b1;
      end else if (uv_s) begin
         lin_rx_output <= 1'b1;
      end else if (rx_hold) begin
         lin_rx_output <= 1'b0;
      end else if (trx == TRX_NORM || trx == TRX_RXO) begin
         lin_rx_output <= bus_s;
      end else begin
         lin_rx_output <= 1'b1;
      end
   end

   // wake reactions on the device side
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_status_reg <= 1'b0;
      end else if (wake_det) begin
         wake_status_reg <= 1'b1;
      end else if (wake_status_clr) begin
         wake_status_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         int_cnt         <= '0;
         interrupt_out_n <= 1'b1;
      end else if (wake_det && (dev_norm || dev_stop)) begin
         int_cnt         <= INT_LIM - 1'b1;
         interrupt_out_n <= 1'b0;
      end else if (int_cnt != '0) begin
         int_cnt <= int_cnt - 1'b1;
      end else begin
         interrupt_out_n <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         restart_req         <= 1'b0;
         watchdog_enable_set <= 1'b0;
      end else begin
         restart_req         <= wake_det && (dev_sleep || dev_fs);
         watchdog_enable_set <= wake_det && dev_stop && !watchdog_active
                                && wake_enables_watchdog;
      end
   end

   // event queue toward the controller; a full queue stalls detection
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_pend <= 1'b0;
      end else if (wake_det) begin
         wake_pend <= 1'b1;
      end else if (fifo_ready) begin
         wake_pend <= 1'b0;
      end
   end

   logic [2:0] pend_mode;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_mode <= 3'h0;
      end else if (wake_det) begin
         pend_mode <= dev_mode;
      end
   end

   lnmc_fifo #(.WIDTH(`LNMC_EVT_W), .DEPTH(`LNMC_FIFO_DEPTH)) u_evt_fifo (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .in_valid  (wake_pend),
      .in_ready  (fifo_ready),
      .in_data   (pend_mode),
      .out_valid (wake_evt_valid),
      .out_ready (wake_evt_ready),
      .out_data  (wake_evt_mode)
   );

   // slope and flash selection taken at select release in normal mode
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         slope_low <= 1'b0;
         slope_off <= 1'b0;
      end else if (!csn_prev && csn_s && dev_norm) begin
         slope_low <= low_slope_select;
         slope_off <= flash_select;
      end
   end

   // run length of dominant bus samples, kept apart from the wake filter
   lnmc_cnt_t low_run;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_run <= '0;
      end else if (bus_s) begin
         low_run <= '0;
      end else if (low_run <= WAKE_LIM) begin
         low_run <= low_run + 1'b1;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_off_no_wake:   assert property (trx == TRX_OFF |=>
                         lin_rx_output && !$rose(wake_status_reg))
      else $error("wake taken in off mode");
   chk_fresh_dominant: assert property (!en_done |=> !lin_bus_drive)
      else $error("drive before enabling done");
   chk_rxo_no_drive:  assert property (trx == TRX_RXO |=> !lin_bus_drive)
      else $error("drive in receive-only");
   chk_failsafe_wake: assert property (fs_entry |=> trx == TRX_WAKE)
      else $error("no wake mode on fail-safe");
   chk_wake_filter:   assert property (wake_det |-> low_run > WAKE_LIM)
      else $error("wake without filter time");
   chk_rx_held_low:   assert property (wake_det && !uv_s ##1 !uv_s |=> !lin_rx_output)
      else $error("receive not low after wake");
   chk_int_on_wake:   assert property (wake_det && (dev_norm || dev_stop) |=>
                         !interrupt_out_n [*2])
      else $error("no interrupt on wake");
   chk_sleep_restart: assert property (wake_det && dev_sleep |=> restart_req)
      else $error("no restart on sleep wake");
   chk_tx_timeout:    assert property (tx_to_evt |=> lin_fail ##1 !lin_bus_drive)
      else $error("time-out not handled");
   chk_uv_stage_off:  assert property (uv_s |=> !lin_bus_drive && lin_rx_output)
      else $error("stages active in undervoltage");
   chk_slope_normal:  assert property ($changed(slope_low) |-> $past(dev_norm))
      else $error("slope changed outside normal");

   cov_wake_normal:  cover property (wake_det && dev_norm);
   cov_wake_sleep:   cover property (wake_det && dev_sleep);
   cov_tx_timeout:   cover property (tx_to_evt);
   cov_fifo_full:    cover property (wake_pend && !fifo_ready);
endmodule
`default_nettype wire

// ### inc/lnmc_defs.svh
`ifndef LNMC_DEFS_SVH
`define LNMC_DEFS_SVH

`define LNMC_CLK_MHZ        40
`define LNMC_EN_TIME_US     20
`define LNMC_EN_CYC         (`LNMC_EN_TIME_US * `LNMC_CLK_MHZ)
`define LNMC_WAKE_FILT_US   30
`define LNMC_WAKE_FILT_CYC  (`LNMC_WAKE_FILT_US * `LNMC_CLK_MHZ)
`define LNMC_TX_TO_US       20000
`define LNMC_BUS_TO_US      20000
`define LNMC_INT_PULSE_US   2
`define LNMC_INT_PULSE_CYC  (`LNMC_INT_PULSE_US * `LNMC_CLK_MHZ)

`define LNMC_MODE_OFF       2'h0
`define LNMC_MODE_WAKE      2'h1
`define LNMC_MODE_RXO       2'h2
`define LNMC_MODE_NORM      2'h3

`define LNMC_SYNC_RST       4'hb
`define LNMC_FIFO_DEPTH     4
`define LNMC_EVT_W          3
`endif

// ### inc/lnmc_pkg.sv
package lnmc_pkg;
   typedef enum logic [3:0] {
      TRX_OFF  = 4'h1,
      TRX_WAKE = 4'h2,
      TRX_RXO  = 4'h4,
      TRX_NORM = 4'h8
   } lnmc_trx_t;

   typedef enum logic [2:0] {
      DEV_NORMAL   = 3'h0,
      DEV_STOP     = 3'h1,
      DEV_SLEEP    = 3'h2,
      DEV_RESTART  = 3'h3,
      DEV_FAILSAFE = 3'h4
   } lnmc_dev_t;

   typedef logic [23:0] lnmc_cnt_t;
endpackage

// ### tb/lnmc_lin_node.sv
`timescale 1ns/100ps
`default_nettype none

module lnmc_lin_node (
   input  wire logic dut_drive,
   input  wire logic other_dom,
   output var  logic bus_level
);
   // pull-up keeps the wire recessive unless some node pulls it dominant
   assign bus_level = ~(dut_drive | other_dom);
endmodule

`default_nettype wire

// ### tb/test_lin_transceiver_mode_control.sv
`timescale 1ns/100ps
`default_nettype none

module test_lin_transceiver_mode_control import lnmc_pkg::*;;
   localparam int TO_CYC = 50;
   logic       sys_clk                = 1'b0;
   logic       rst_n                  = 1'b0;
   logic       lin_tx_input           = 1'b1;
   logic       other_dom              = 1'b0;
   logic [2:0] dev_mode               = DEV_NORMAL;
   logic [1:0] trx_mode_req           = 2'h0;
   logic       trx_mode_wr            = 1'b0;
   logic       battery_side_supply_uv = 1'b0;
   logic       serial_select_n        = 1'b1;
   logic       low_slope_select       = 1'b0;
   logic       flash_select           = 1'b0;
   logic       wake_enables_watchdog  = 1'b1;
   logic       watchdog_active        = 1'b0;
   logic       wake_status_clr        = 1'b0;
   logic       lin_fail_clr           = 1'b0;
   logic       wake_evt_ready         = 1'b0;
   logic       lin_bus_in;
   logic       lin_bus_drive, lin_rx_output, interrupt_out_n, slope_low, slope_off;
   logic       watchdog_enable_set, restart_req, wake_status_reg, lin_fail, wake_evt_valid;
   logic [1:0] trx_mode_rd;
   logic [2:0] wake_evt_mode;
   int         bad_count = 0;
   int         n_checks = 0;
   int         n_rst, n_wd, n_int, m;
   int         exp_q[$];
   logic       prev;

   lnmc_core #(.TX_TO_CYC(TO_CYC), .BUS_TO_CYC(TO_CYC)) dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .lin_tx_input(lin_tx_input),
      .lin_bus_in(lin_bus_in), .lin_bus_drive(lin_bus_drive),
      .lin_rx_output(lin_rx_output), .interrupt_out_n(interrupt_out_n),
      .dev_mode(dev_mode), .trx_mode_req(trx_mode_req), .trx_mode_wr(trx_mode_wr),
      .trx_mode_rd(trx_mode_rd), .battery_side_supply_uv(battery_side_supply_uv),
      .serial_select_n(serial_select_n), .low_slope_select(low_slope_select),
      .flash_select(flash_select), .slope_low(slope_low), .slope_off(slope_off),
      .wake_enables_watchdog(wake_enables_watchdog), .watchdog_active(watchdog_active),
      .watchdog_enable_set(watchdog_enable_set), .restart_req(restart_req),
      .wake_status_reg(wake_status_reg), .wake_status_clr(wake_status_clr),
      .lin_fail(lin_fail), .lin_fail_clr(lin_fail_clr), .wake_evt_valid(wake_evt_valid),
      .wake_evt_mode(wake_evt_mode), .wake_evt_ready(wake_evt_ready)
   );

   lnmc_lin_node node (.dut_drive(lin_bus_drive), .other_dom(other_dom), .bus_level(lin_bus_in));

   always #12.5 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      if (restart_req === 1'b1) n_rst++;
      if (watchdog_enable_set === 1'b1) n_wd++;
      if (interrupt_out_n === 1'b0) n_int++;
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_mode(input logic [1:0] m);
      trx_mode_req = m;
      trx_mode_wr = 1'b1;
      cyc(1);
      trx_mode_wr = 1'b0;
      cyc(2);
   endtask

   task automatic bus_dom(input int n);
      other_dom = 1'b1;
      cyc(n);
      other_dom = 1'b0;
      cyc(6);
   endtask

   task automatic sel_pulse;
      serial_select_n = 1'b0;
      cyc(3);
      serial_select_n = 1'b1;
      cyc(5);
   endtask

   task automatic pulse_clr;
      wake_status_clr = 1'b1;
      lin_fail_clr = 1'b1;
      cyc(1);
      wake_status_clr = 1'b0;
      lin_fail_clr = 1'b0;
      cyc(1);
   endtask

   task automatic drain;
      int w;
      while (exp_q.size() > 0) begin
         w = 0;
         while (wake_evt_valid !== 1'b1 && w < 8) begin
            cyc(1);
            w++;
         end
         if (wake_evt_valid !== 1'b1) begin
            bad_count++;
            $display("mismatch evt_valid expected 1 seen timeout");
            close_out;
         end else begin
            chk("evt_mode", 8'(exp_q.pop_front()), wake_evt_mode);
            wake_evt_ready = 1'b1;
            cyc(1);
            wake_evt_ready = 1'b0;
         end
      end
      cyc(3);
      chk("evt_empty", 0, wake_evt_valid);
   endtask

   initial begin
      #(60000 * 25);
      bad_count++;
      $display("mismatch run expected finish seen timeout");
      close_out;
   end

   initial begin
      void'($urandom(47));
      cyc(20);
      rst_n = 1'b1;
      cyc(2);
      chk("mode_rst", 0, trx_mode_rd);
      chk("slope_rst", 0, {slope_low, slope_off});
      bus_dom(1300);
      chk("off_wake", 0, wake_status_reg);
      chk("off_rx", 1, lin_rx_output);
      $display("test power_up_off done");

      // dominant at entry and across end of enabling must not be sent
      lin_tx_input = 1'b0;
      wr_mode(2'h3);
      chk("mode_norm", 3, trx_mode_rd);
      cyc(20);
      chk("drive_early", 0, lin_bus_drive);
      lin_tx_input = 1'b1;
      cyc(760);
      lin_tx_input = 1'b0;
      cyc(30);
      chk("drive_stale", 0, lin_bus_drive);
      lin_tx_input = 1'b1;
      cyc(4);
      prev = 1'b1;
      for (int i = 0; i < 40; i++) begin
         lin_tx_input = prev ? 1'($urandom) : 1'b1;
         // bus never dominant two slots in a row, so no clamp is flagged
         other_dom = (lin_tx_input && prev) ? 1'($urandom) : 1'b0;
         prev = lin_tx_input && !other_dom;
         cyc(8);
         chk("drive_bit", !lin_tx_input, lin_bus_drive);
         chk("rx_bit", lin_tx_input & !other_dom, lin_rx_output);
      end
      other_dom = 1'b0;
      lin_tx_input = 1'b0;
      cyc(40);
      lin_tx_input = 1'b1;
      cyc(4);
      lin_tx_input = 1'b0;
      cyc(40);
      chk("fail_split", 0, lin_fail);
      chk("drive_split", 1, lin_bus_drive);
      cyc(TO_CYC);
      chk("drive_to", 0, lin_bus_drive);
      chk("fail_to", 1, lin_fail);
      chk("mode_to", 3, trx_mode_rd);
      lin_tx_input = 1'b1;
      cyc(5);
      lin_tx_input = 1'b0;
      cyc(5);
      chk("drive_back", 1, lin_bus_drive);
      lin_tx_input = 1'b1;
      pulse_clr();
      chk("fail_clr", 0, lin_fail);
      $display("test transmit done");

      battery_side_supply_uv = 1'b1;
      cyc(4);
      lin_tx_input = 1'b0;
      other_dom = 1'b1;
      cyc(8);
      chk("drive_uv", 0, lin_bus_drive);
      chk("rx_uv", 1, lin_rx_output);
      lin_tx_input = 1'b1;
      other_dom = 1'b0;
      battery_side_supply_uv = 1'b0;
      cyc(6);
      lin_tx_input = 1'b0;
      cyc(6);
      chk("drive_uv_end", 1, lin_bus_drive);
      chk("mode_uv", 3, trx_mode_rd);
      lin_tx_input = 1'b1;
      cyc(4);
      $display("test undervoltage done");

      dev_mode = DEV_STOP;
      low_slope_select = 1'b1;
      flash_select = 1'b1;
      sel_pulse();
      chk("slope_stop", 0, {slope_low, slope_off});
      dev_mode = DEV_NORMAL;
      cyc(4);
      chk("slope_no_edge", 0, {slope_low, slope_off});
      sel_pulse();
      chk("slope_set", 3, {slope_low, slope_off});
      low_slope_select = 1'b0;
      flash_select = 1'b0;
      sel_pulse();
      chk("slope_norm", 0, {slope_low, slope_off});
      $display("test slope done");

      dev_mode = DEV_STOP;
      wr_mode(2'h2);
      chk("mode_rxo", 2, trx_mode_rd);
      lin_tx_input = 1'b0;
      other_dom = 1'b1;
      cyc(8);
      chk("drive_rxo", 0, lin_bus_drive);
      chk("rx_rxo", 0, lin_rx_output);
      lin_tx_input = 1'b1;
      cyc(TO_CYC + 10);
      chk("fail_clamp", 1, lin_fail);
      chk("mode_clamp", 2, trx_mode_rd);
      other_dom = 1'b0;
      pulse_clr();
      $display("test receive_only done");

      // last pass repeats stop with the watchdog already running
      for (int d = 0; d < 6; d++) begin
         m = (d == 5) ? 1 : d;
         dev_mode = 3'(m);
         watchdog_active = (d == 5);
         cyc(4);
         if (d == 0 || d == 3) begin
            wr_mode(2'h0);
            chk("rx_release", 1, lin_rx_output);
         end
         if (m != 4) wr_mode(2'h1);
         chk("mode_wake", 1, trx_mode_rd);
         bus_dom(200);
         chk("wake_short", 0, wake_status_reg);
         n_rst = 0;
         n_wd = 0;
         n_int = 0;
         bus_dom(1300);
         exp_q.push_back(m);
         chk("wake_stat", 1, wake_status_reg);
         chk("wake_rx", 0, lin_rx_output);
         cyc(100);
         chk("wake_int", (m < 2) ? 8'd80 : 8'd0, 8'(n_int));
         chk("wake_restart", (m == 2 || m == 4), 8'(n_rst));
         chk("wake_wdog", (m == 1 && !watchdog_active), 8'(n_wd));
         chk("wake_mode", 1, trx_mode_rd);
         if (m == 2) wr_mode(2'h2);
         chk("rx_held", 0, lin_rx_output);
         pulse_clr();
         if (m != 4) wr_mode(2'h1);
         bus_dom(1300);
         chk("no_rearm", 0, wake_status_reg);
         if (d == 3) drain();
      end
      drain();
      $display("test wake done");
      close_out();
   end
endmodule

`default_nettype wire
